// File: verilog/pimd_defs.vh
// Constants for the pulse input mode decoder
`ifndef PIMD_DEFS_VH
`define PIMD_DEFS_VH

// ---------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ---------------------------------------------------------------
`define PIMD_ADDR_W          4
`define PIMD_OFF_MODE0       4'h0
`define PIMD_OFF_MODE1       4'h1
`define PIMD_OFF_COND0       4'h2
`define PIMD_OFF_COND1       4'h3
`define PIMD_OFF_ROUTE       4'h4
`define PIMD_OFF_STATUS      4'h5
`define PIMD_OFF_VARIANT     4'h6

// ---------------------------------------------------------------
// Mode codes: bits 3:1 select the family, bit 0 picks down
// ---------------------------------------------------------------
`define PIMD_MODE_W          4
`define PIMD_MODE_USER       4'h0
`define PIMD_MODE_P1X1_UP    4'h2
`define PIMD_MODE_P1X1_DN    4'h3
`define PIMD_MODE_P1X2_UP    4'h4
`define PIMD_MODE_P1X2_DN    4'h5
`define PIMD_MODE_CW_UP      4'h6
`define PIMD_MODE_CW_DN      4'h7
`define PIMD_MODE_P2X1_UP    4'h8
`define PIMD_MODE_P2X1_DN    4'h9
`define PIMD_MODE_P2X2_UP    4'hA
`define PIMD_MODE_P2X2_DN    4'hB
`define PIMD_MODE_P2X4_UP    4'hC
`define PIMD_MODE_P2X4_DN    4'hD

// ---------------------------------------------------------------
// Detection condition bit positions (bit n-1 is condition n)
// ---------------------------------------------------------------
`define PIMD_NCOND           16
`define PIMD_C_A_RISE        0
`define PIMD_C_A_FALL        1
`define PIMD_C_A_LOW         2
`define PIMD_C_A_HIGH        3
`define PIMD_C_B_RISE        4
`define PIMD_C_B_FALL        5
`define PIMD_C_B_LOW         6
`define PIMD_C_B_HIGH        7
`define PIMD_C_AR_BL         8
`define PIMD_C_AR_BH         9
`define PIMD_C_AF_BL         10
`define PIMD_C_AF_BH         11
`define PIMD_C_AL_BR         12
`define PIMD_C_AH_BR         13
`define PIMD_C_AL_BF         14
`define PIMD_C_AH_BF         15

// ---------------------------------------------------------------
// Route field: 0 none, 1 counter up, 2 counter down, 3 run,
// 4 stop, 5 preset, 6 set/reset output; bit 4 enables, bit 5 picks event line
// ---------------------------------------------------------------
`define PIMD_ROUTE_W         4
`define PIMD_DST_NONE        3'h0
`define PIMD_DST_UP          3'h1
`define PIMD_DST_DOWN        3'h2
`define PIMD_DST_RUN         3'h3
`define PIMD_DST_STOP        3'h4
`define PIMD_DST_PRESET      3'h5
`define PIMD_DST_SETRST      3'h6
`define PIMD_ROUTE_EVT_EN    4
`define PIMD_ROUTE_EVT_SEL   5

// Reset values
`define PIMD_RST_MODE        4'h0
`define PIMD_RST_COND        16'h0000
`define PIMD_RST_ROUTE       12'h000

`endif

// File: verilog/pimd_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pimd_sync #(
  parameter RST_VAL = 1'b0            // Level held during reset
) (
  input  wire sys_clk_i,              // Module clock
  input  wire sys_rst_i,              // Synchronous reset, active high
  input  wire pin_i,                  // Asynchronous pin
  output reg  level_o                 // Filtered, clean level
);

  // -------------------------------------------------------------
  // Sampling chain
  // -------------------------------------------------------------
  reg s1;                             // Metastable stage, read only by s2
  reg s2;                             // Second stage
  reg s3;                             // Third stage

  // Chain; level moves only once stages two and three agree
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s1      <= RST_VAL;
      s2      <= RST_VAL;
      s3      <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin             // Agreement required
        level_o <= s3;
      end
    end
  end

endmodule

// File: verilog/pimd_top.v
// Pulse input mode decoder: two phase inputs into two detector pulses
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "pimd_defs.vh"
module pimd_top #(
  parameter NDET = 2,                 // Number of detectors
  parameter NCOND = 16                // Conditions per detector
) (
  input  wire        sys_clk_i,       // 20 MHz module clock
  input  wire        sys_rst_i,       // Synchronous reset, active high
  input  wire        phase_a_i,       // Phase A pin
  input  wire        phase_b_i,       // Phase B pin
  input  wire        cnt16_i,         // 1: 16-bit counter variant, 0: 32-bit
  input  wire [3:0]  addr_i,          // Register word address
  input  wire [15:0] wdata_i,         // Write data
  input  wire        wr_i,            // Write strobe
  input  wire        rd_i,            // Read strobe
  output reg  [15:0] rdata_o,         // Read data, one cycle after strobe
  output reg  [1:0]  det_o,           // Raw detector outputs
  output reg         cnt_up_o,        // Counter up terminal
  output reg         cnt_down_o,      // Counter down terminal
  output reg         cnt_run_o,       // Counter run terminal
  output reg         cnt_stop_o,      // Counter stop terminal
  output reg         cnt_preset_o,    // Counter preset terminal
  output reg  [1:0]  setrst_o,        // Set/reset output block strobes
  output reg  [3:0]  event_o          // Event output lines
);

  // -------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------

  // Condition mask for a pulse input mode; user mode uses own mask
  function [15:0] mode_mask;
    input [3:0]  mode;
    input [15:0] user;
    begin
      mode_mask = 16'h0000;
      case (mode)
        `PIMD_MODE_P1X1_UP: mode_mask[`PIMD_C_AR_BL] = 1'b1;
        `PIMD_MODE_P1X1_DN: mode_mask[`PIMD_C_AF_BH] = 1'b1;
        `PIMD_MODE_P1X2_UP: begin
          mode_mask[`PIMD_C_AR_BL] = 1'b1;
          mode_mask[`PIMD_C_AF_BL] = 1'b1;
        end
        `PIMD_MODE_P1X2_DN: begin
          mode_mask[`PIMD_C_AR_BH] = 1'b1;
          mode_mask[`PIMD_C_AF_BH] = 1'b1;
        end
        `PIMD_MODE_CW_UP: mode_mask[`PIMD_C_AR_BL] = 1'b1;
        `PIMD_MODE_CW_DN: mode_mask[`PIMD_C_AL_BR] = 1'b1;
        `PIMD_MODE_P2X1_UP: mode_mask[`PIMD_C_AR_BL] = 1'b1;
        `PIMD_MODE_P2X1_DN: mode_mask[`PIMD_C_AF_BL] = 1'b1;
        `PIMD_MODE_P2X2_UP: begin
          mode_mask[`PIMD_C_AR_BL] = 1'b1;
          mode_mask[`PIMD_C_AF_BH] = 1'b1;
        end
        `PIMD_MODE_P2X2_DN: begin
          mode_mask[`PIMD_C_AR_BH] = 1'b1;
          mode_mask[`PIMD_C_AF_BL] = 1'b1;
        end
        `PIMD_MODE_P2X4_UP: begin
          mode_mask[`PIMD_C_AR_BL] = 1'b1;
          mode_mask[`PIMD_C_AF_BH] = 1'b1;
          mode_mask[`PIMD_C_AH_BR] = 1'b1;
          mode_mask[`PIMD_C_AL_BF] = 1'b1;
        end
        `PIMD_MODE_P2X4_DN: begin
          mode_mask[`PIMD_C_AR_BH] = 1'b1;
          mode_mask[`PIMD_C_AF_BL] = 1'b1;
          mode_mask[`PIMD_C_AL_BR] = 1'b1;
          mode_mask[`PIMD_C_AH_BF] = 1'b1;
        end
        default: mode_mask = user;    // User setting or unused code
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------
  wire a_lvl;                         // Clean phase A
  wire b_lvl;                         // Clean phase B

  pimd_sync #(.RST_VAL(1'b0)) u_sync_a (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (phase_a_i),
    .level_o   (a_lvl)
  );

  pimd_sync #(.RST_VAL(1'b0)) u_sync_b (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (phase_b_i),
    .level_o   (b_lvl)
  );

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  reg  [3:0]  mode0;                  // Detector 0 pulse input mode
  reg  [3:0]  mode1;                  // Detector 1 pulse input mode
  reg  [15:0] cond0;                  // Detector 0 user condition mask
  reg  [15:0] cond1;                  // Detector 1 user condition mask
  reg  [11:0] route;                  // Two 6-bit route fields
  reg         a_prev;                 // Previous phase A sample
  reg         b_prev;                 // Previous phase B sample
  reg  [1:0]  sticky;                 // Detector seen since last read
  reg         cnt16;                  // Captured variant strap

  // -------------------------------------------------------------
  // Condition vector
  // -------------------------------------------------------------
  // Edges compare the clean level with its registered copy
  wire a_rise = a_lvl & ~a_prev;
  wire a_fall = ~a_lvl & a_prev;
  wire b_rise = b_lvl & ~b_prev;
  wire b_fall = ~b_lvl & b_prev;

  // Edge terms last one cycle, so combined conditions pulse once
  wire [15:0] cond_vec = {
    a_lvl & b_fall,                   // 16 A high + B fall
    ~a_lvl & b_fall,                  // 15 A low + B fall
    a_lvl & b_rise,                   // 14 A high + B rise
    ~a_lvl & b_rise,                  // 13 A low + B rise
    a_fall & b_lvl,                   // 12 A fall + B high
    a_fall & ~b_lvl,                  // 11 A fall + B low
    a_rise & b_lvl,                   // 10 A rise + B high
    a_rise & ~b_lvl,                  // 9 A rise + B low
    b_lvl, ~b_lvl, b_fall, b_rise,    // 8..5
    a_lvl, ~a_lvl, a_fall, a_rise     // 4..1
  };

  // -------------------------------------------------------------
  // Detector evaluation
  // -------------------------------------------------------------
  wire [15:0] mask0 = mode_mask(mode0, cond0);
  wire [15:0] mask1 = mode_mask(mode1, cond1);
  wire [1:0]  next_det;               // Any enabled condition met

  assign next_det[0] = |(cond_vec & mask0);
  assign next_det[1] = |(cond_vec & mask1);

  // -------------------------------------------------------------
  // Routing of each detector
  // -------------------------------------------------------------
  reg       next_up;
  reg       next_down;
  reg       next_run;
  reg       next_stop;
  reg       next_preset;
  reg [1:0] next_setrst;
  reg [3:0] next_event;
  integer   k;

  // Decode destination fields; several detectors OR together
  always @* begin
    next_up     = 1'b0;
    next_down   = 1'b0;
    next_run    = 1'b0;
    next_stop   = 1'b0;
    next_preset = 1'b0;
    next_setrst = 2'b00;
    next_event  = 4'h0;
    for (k = 0; k < NDET; k = k + 1) begin
      case (route[k*6 +: 3])
        `PIMD_DST_UP:     next_up     = next_up     | next_det[k];
        `PIMD_DST_DOWN:   next_down   = next_down   | next_det[k];
        `PIMD_DST_RUN:    next_run    = next_run    | next_det[k];
        `PIMD_DST_STOP:   next_stop   = next_stop   | next_det[k];
        `PIMD_DST_PRESET: next_preset = next_preset | next_det[k];
        `PIMD_DST_SETRST: next_setrst[k] = next_det[k];
        default: ;                    // Unrouted
      endcase
      // Event lines: detector k owns lines 2k and 2k+1, 16-bit only
      if (cnt16 && route[k*6 + `PIMD_ROUTE_EVT_EN]) begin
        next_event[k*2 + route[k*6 + `PIMD_ROUTE_EVT_SEL]] = next_det[k];
      end
    end
  end

  // -------------------------------------------------------------
  // Register write, state and outputs
  // -------------------------------------------------------------
  // Outputs are registered, adding one cycle after the edge
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode0        <= `PIMD_RST_MODE;
      mode1        <= `PIMD_RST_MODE;
      cond0        <= `PIMD_RST_COND;
      cond1        <= `PIMD_RST_COND;
      route        <= `PIMD_RST_ROUTE;
      a_prev       <= 1'b0;
      b_prev       <= 1'b0;
      sticky       <= 2'b00;
      cnt16        <= 1'b0;
      det_o        <= 2'b00;
      cnt_up_o     <= 1'b0;
      cnt_down_o   <= 1'b0;
      cnt_run_o    <= 1'b0;
      cnt_stop_o   <= 1'b0;
      cnt_preset_o <= 1'b0;
      setrst_o     <= 2'b00;
      event_o      <= 4'h0;
    end else begin
      a_prev       <= a_lvl;          // Previous sample
      b_prev       <= b_lvl;
      cnt16        <= cnt16_i;        // Strap resampled every cycle after release
      det_o        <= next_det;       // One cycle per match
      cnt_up_o     <= next_up;
      cnt_down_o   <= next_down;
      cnt_run_o    <= next_run;
      cnt_stop_o   <= next_stop;
      cnt_preset_o <= next_preset;
      setrst_o     <= next_setrst;
      event_o      <= next_event;
      // Sticky: a new detection wins over the read that clears it
      if (rd_i && addr_i == `PIMD_OFF_STATUS) begin
        sticky <= next_det;
      end else begin
        sticky <= sticky | next_det;
      end
      // Register writes
      if (wr_i) begin
        if (addr_i == `PIMD_OFF_MODE0) begin
          mode0 <= wdata_i[3:0];
        end else if (addr_i == `PIMD_OFF_MODE1) begin
          mode1 <= wdata_i[3:0];
        end else if (addr_i == `PIMD_OFF_COND0) begin
          cond0 <= wdata_i;
        end else if (addr_i == `PIMD_OFF_COND1) begin
          cond1 <= wdata_i;
        end else if (addr_i == `PIMD_OFF_ROUTE) begin
          route <= wdata_i[11:0];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------
  // Data valid only in the cycle after the strobe, else zero
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else if (addr_i == `PIMD_OFF_MODE0) begin
      rdata_o <= {12'h000, mode0};
    end else if (addr_i == `PIMD_OFF_MODE1) begin
      rdata_o <= {12'h000, mode1};
    end else if (addr_i == `PIMD_OFF_COND0) begin
      rdata_o <= cond0;
    end else if (addr_i == `PIMD_OFF_COND1) begin
      rdata_o <= cond1;
    end else if (addr_i == `PIMD_OFF_ROUTE) begin
      rdata_o <= {4'h0, route};
    end else if (addr_i == `PIMD_OFF_STATUS) begin
      rdata_o <= {12'h000, b_lvl, a_lvl, sticky};
    end else if (addr_i == `PIMD_OFF_VARIANT) begin
      rdata_o <= {15'h0000, cnt16};
    end else begin
      rdata_o <= 16'h0000;           // Unmapped reads zero
    end
  end

endmodule

// File: tb/pimd_asserts.sv
// Port-level assertion checker for the pulse input mode decoder
`timescale 1ns/1ns
`include "pimd_defs.vh"
module pimd_asserts (
  input wire        sys_clk_i,     // Module clock
  input wire        sys_rst_i,     // Synchronous reset
  input wire        phase_a_i,     // Phase A pin
  input wire        phase_b_i,     // Phase B pin
  input wire        cnt16_i,       // Counter variant
  input wire [3:0]  addr_i,        // Register address
  input wire [15:0] wdata_i,       // Write data
  input wire        wr_i,          // Write strobe
  input wire        rd_i,          // Read strobe
  input wire [15:0] rdata_o,       // Read data
  input wire [1:0]  det_o,         // Detector pulses
  input wire        cnt_up_o,      // Up terminal
  input wire        cnt_down_o,    // Down terminal
  input wire        cnt_run_o,     // Run terminal
  input wire        cnt_stop_o,    // Stop terminal
  input wire        cnt_preset_o,  // Preset terminal
  input wire [1:0]  setrst_o,      // Set/reset strobes
  input wire [3:0]  event_o        // Event lines
);
  // ---------------------------------------------------------------
  // Clocking and reset for every property
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_reset_quiet: assert property (
    $fell(sys_rst_i) |-> det_o == 2'h0 && event_o == 4'h0 && rdata_o == 16'h0000)
    else $error("outputs busy right after reset");
  // A pulse needs a pin edge that crossed the synchroniser lately
  a_det_edge: assert property (
    $rose(|det_o) |-> $past(phase_a_i, 2) != $past(phase_a_i, 9)
      || $past(phase_b_i, 2) != $past(phase_b_i, 9))
    else $error("detector pulse without a pin edge");
  a_det_single: assert property (
    det_o[0] |=> !det_o[0])
    else $error("detector 0 pulse longer than one cycle");
  a_det1_single: assert property (
    $rose(det_o[1]) |=> $fell(det_o[1]))
    else $error("detector 1 pulse longer than one cycle");
  a_route_src: assert property (
    (cnt_up_o || cnt_down_o || cnt_run_o || cnt_stop_o || cnt_preset_o)
      |-> det_o != 2'h0 || $past(det_o) != 2'h0)
    else $error("counter terminal without detection");
  a_setrst_src: assert property (
    (!setrst_o[0] || det_o[0] || $past(det_o[0]))
      && (!setrst_o[1] || det_o[1] || $past(det_o[1])))
    else $error("set/reset strobe from wrong detector");
  a_event_src: assert property (
    (event_o[1:0] == 2'h0 || det_o[0] || $past(det_o[0]))
      && (event_o[3:2] == 2'h0 || det_o[1] || $past(det_o[1])))
    else $error("event line from wrong detector");
  a_event_pick: assert property (
    !(event_o[0] && event_o[1]) && !(event_o[2] && event_o[3]))
    else $error("two event lines from one detector");
  a_event_32bit: assert property (
    event_o != 4'h0 |-> $past(cnt16_i) || $past(cnt16_i, 2) || $past(cnt16_i, 3))
    else $error("event line in 32-bit variant");
  a_variant_read: assert property (
    $past(rd_i) && $past(addr_i) == `PIMD_OFF_VARIANT
      |-> rdata_o == {15'h0000, $past(cnt16_i, 2)})
    else $error("variant read does not match input");
endmodule

bind pimd_top pimd_asserts i_pimd_asserts (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .phase_a_i(phase_a_i),
  .phase_b_i(phase_b_i), .cnt16_i(cnt16_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .det_o(det_o), .cnt_up_o(cnt_up_o),
  .cnt_down_o(cnt_down_o), .cnt_run_o(cnt_run_o), .cnt_stop_o(cnt_stop_o),
  .cnt_preset_o(cnt_preset_o), .setrst_o(setrst_o), .event_o(event_o)
);

// File: tb/pimd_pulse_gen.sv
// Encoder model driving the two phase pins
`timescale 1ns/1ns
module pimd_pulse_gen #(
  parameter HOLD = 10          // Cycles waited after each move; a level stands one cycle more
) (
  input  wire sys_clk_i,       // Module clock
  output reg  phase_a_o,       // Phase A line
  output reg  phase_b_o        // Phase B line
);
  // Encoder rests with both phases low
  initial begin
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
  end
  // Move lines after an edge, then hold them well past the
  // filter depth so no edge is dropped as a glitch
  task automatic drive(input logic na, input logic nb);
    @(posedge sys_clk_i);
    phase_a_o <= na;
    phase_b_o <= nb;
    repeat (HOLD) @(posedge sys_clk_i);
  endtask
endmodule

// File: tb/tb_pimd_top.sv
// Self-checking testbench for the pulse input mode decoder
`timescale 1ns/1ns
`include "pimd_defs.vh"
module tb_pimd_top;
  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  reg          clk   = 1'b0;      // 20 MHz clock
  reg          rst   = 1'b1;      // Reset, high at start
  reg          cnt16 = 1'b0;      // Counter variant
  reg  [3:0]   addr  = 4'h0;      // Register address
  reg  [15:0]  wdata = 16'h0000;  // Write data
  reg          wr    = 1'b0;      // Write strobe
  reg          rd    = 1'b0;      // Read strobe
  wire         pa, pb, up, dn, run, stp, pre;
  wire [15:0]  rdata;
  wire [1:0]   det, setrst;
  wire [3:0]   evt;
  wire [12:0]  obs = {evt, setrst, pre, stp, run, dn, up, det};
  int          tally [13];        // High cycles per output bit
  logic [15:0] hitlog [16];       // Conditions met per driven edge
  int          hitn;
  int          fails = 0;
  int          checks_done = 0;

  always #25 clk = ~clk;

  pimd_pulse_gen i_pimd_pulse_gen (.sys_clk_i(clk), .phase_a_o(pa), .phase_b_o(pb));
  pimd_top i_pimd_top (
    .sys_clk_i(clk), .sys_rst_i(rst), .phase_a_i(pa), .phase_b_i(pb), .cnt16_i(cnt16),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .det_o(det),
    .cnt_up_o(up), .cnt_down_o(dn), .cnt_run_o(run), .cnt_stop_o(stp),
    .cnt_preset_o(pre), .setrst_o(setrst), .event_o(evt));

  // Pulses are one cycle, so high cycles equal events
  always @(posedge clk)
    for (int k = 0; k < 13; k++) if (obs[k] === 1'b1) tally[k]++;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Fixed condition subset of each mode code
  function automatic logic [15:0] mask_of(input logic [3:0] m);
    case (m)
      4'h3: mask_of = 16'h0800;
      4'h4: mask_of = 16'h0500;
      4'h5: mask_of = 16'h0A00;
      4'h7: mask_of = 16'h1000;
      4'h9: mask_of = 16'h0400;
      4'hA: mask_of = 16'h0900;
      4'hB: mask_of = 16'h0600;
      4'hC: mask_of = 16'h6900;
      4'hD: mask_of = 16'h9600;
      default: mask_of = 16'h0100;
    endcase
  endfunction
  function automatic int hits(input logic [15:0] mk);
    hits = 0;
    for (int i = 0; i < 16; i++) if ((hitlog[i] & mk) != 16'h0000) hits++;
  endfunction
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdata, exp);
  endtask
  // One pin step; logs which combined or edge conditions it meets
  task automatic step(input logic [1:0] s);
    logic ar, af, br, bf;
    ar = s[1] & !pa;
    af = !s[1] & pa;
    br = s[0] & !pb;
    bf = !s[0] & pb;
    hitlog[hitn] = {bf & pa, bf & !pa, br & pa, br & !pa, af & pb, af & !pb,
                    ar & pb, ar & !pb, 2'h0, bf, br, 2'h0, af, ar};
    hitn++;
    i_pimd_pulse_gen.drive(s[1], s[0]);
  endtask
  // Two cycles forward then two back: every edge/level pairing occurs
  task automatic pattern;
    hitn = 0;
    for (int i = 0; i < 13; i++) tally[i] = 0;
    repeat (2) begin
      step(2'h2); step(2'h3); step(2'h1); step(2'h0);
    end
    repeat (2) begin
      step(2'h1); step(2'h3); step(2'h2); step(2'h0);
    end
    repeat (4) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd_chk(`PIMD_OFF_MODE0, 16'h0000);
    rd_chk(`PIMD_OFF_ROUTE, 16'h0000);
    wr_reg(`PIMD_OFF_MODE1, 16'hFFF5);
    rd_chk(`PIMD_OFF_MODE1, 16'h0005);
    wr_reg(`PIMD_OFF_COND0, 16'hA533);
    rd_chk(`PIMD_OFF_COND0, 16'hA533);
    wr_reg(4'hF, 16'hFFFF);
    rd_chk(4'hF, 16'h0000);
    rd_chk(`PIMD_OFF_VARIANT, 16'h0000);
    $display("test regs done");
  endtask
  // Up variant on detector 0 to up, down variant on detector 1 to down
  task automatic t_family(input logic [3:0] m);
    wr_reg(`PIMD_OFF_MODE0, {12'h000, m});
    wr_reg(`PIMD_OFF_MODE1, {12'h000, m | 4'h1});
    wr_reg(`PIMD_OFF_ROUTE, 16'h0081);
    pattern;
    chk_cnt(tally[0], hits(mask_of(m)));
    chk_cnt(tally[1], hits(mask_of(m | 4'h1)));
    chk_cnt(tally[2], hits(mask_of(m)));
    chk_cnt(tally[3], hits(mask_of(m | 4'h1)));
    $display("test mode %h done", m);
  endtask
  task automatic t_user;
    wr_reg(`PIMD_OFF_MODE0, 16'h0000);
    wr_reg(`PIMD_OFF_MODE1, 16'h0000);
    wr_reg(`PIMD_OFF_COND0, 16'h0033);
    wr_reg(`PIMD_OFF_COND1, 16'hFF00);
    wr_reg(`PIMD_OFF_ROUTE, 16'h0103);
    pattern;
    chk_cnt(tally[4], hits(16'h0033));
    chk_cnt(tally[5], hits(16'hFF00));
    chk_cnt(tally[2], 0);
    rd_chk(`PIMD_OFF_STATUS, 16'h0003);
    rd_chk(`PIMD_OFF_STATUS, 16'h0000);
    wr_reg(`PIMD_OFF_ROUTE, 16'h0185);
    pattern;
    chk_cnt(tally[6], hits(16'h0033));
    chk_cnt(tally[8], hits(16'hFF00));
    chk_cnt(tally[7] + tally[4], 0);
    $display("test user done");
  endtask
  task automatic t_event;
    @(posedge clk);
    cnt16 <= 1'b1;
    wr_reg(`PIMD_OFF_ROUTE, 16'h0430);
    rd_chk(`PIMD_OFF_VARIANT, 16'h0001);
    pattern;
    chk_cnt(tally[10], hits(16'h0033));
    chk_cnt(tally[11], hits(16'hFF00));
    chk_cnt(tally[9] + tally[12], 0);
    @(posedge clk);
    cnt16 <= 1'b0;
    pattern;
    chk_cnt(tally[10] + tally[11], 0);
    $display("test event done");
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`PIMD_OFF_MODE0, 16'h0000);
    rd_chk(`PIMD_OFF_COND1, 16'h0000);
    $display("test reset done");
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_family(`PIMD_MODE_P1X1_UP);
    t_family(`PIMD_MODE_P1X2_UP);
    t_family(`PIMD_MODE_CW_UP);
    t_family(`PIMD_MODE_P2X1_UP);
    t_family(`PIMD_MODE_P2X2_UP);
    t_family(`PIMD_MODE_P2X4_UP);
    t_user;
    t_event;
    t_reset;
    close_out;
  end
  // About 1900 cycles expected; allow ample margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    close_out;
  end
endmodule
